//--- acc_regs.vh
// register map, field positions and reset values of the comparator control
// Summary of operation
// [R1] output level high when plus terminal above minus terminal, comparator powered
// [R2] software power-on bit switches the comparator on or off
// [R3] comparator off: output level held low regardless of inputs
// [R4] swap bit exchanges terminal inputs and inverts the output
// [R5] filter select bit chooses filtered or unfiltered output
// [R6] reference is applied to the terminal chosen by reference terminal select
// [R7] reference level field picks off, supply fractions, or fixed 0.55 V threshold
// [R8] input switch bits connect each terminal to its pin independently
// [R9] each set buffer disable bit disables that pin's digital input buffer
// [R10] event flag set on rising edge when polarity is 0, falling when 1
// [R11] interrupt request only while flag, event enable and global enable set
// [R12] flag clears when interrupt serviced, or by software write
// [R13] comparator output routed to the timer capture input
// [R14] exactly one event flag and one interrupt vector; code adds irq_stat_q and o_irq_line besides the flag and o_irq_req
// [R15] output synchronised before edge detection, one-cycle edge pulse
// [R16] swap clear: reference on plus when select 0, minus when 1
`ifndef ACC_REGS_VH
`define ACC_REGS_VH

// ****************************************
// register offsets
// ****************************************
`define ACC_ADDR_W 8
`define ACC_OFS_CTL1 8'h59
`define ACC_OFS_CTL2 8'h5a
`define ACC_OFS_PBD 8'h5b
`define ACC_OFS_IRQ 8'h5c
`define ACC_OFS_MASK 8'h5d

// ****************************************
// control one fields
// ****************************************
`define ACC_B_FLAG 0
`define ACC_B_EN 1
`define ACC_B_POL 2
`define ACC_B_ON 3
`define ACC_B_REFLO 4
`define ACC_B_REFHI 5
`define ACC_B_RSEL 6
`define ACC_B_SWAP 7

// ****************************************
// control two fields
// ****************************************
`define ACC_B_OUT 0
`define ACC_B_FILT 2
`define ACC_B_SW0 3
`define ACC_B_SW1 4
`define ACC_CTL2_WMASK 8'hfe

// ****************************************
// reference level, reset values, filter length and constant one
// ****************************************
`define ACC_REF_OFF 2'h0
`define ACC_RST_BYTE 8'h00
`define ACC_RST_BIT 1'b0
`define ACC_FILT_LEN 3'h4
`define ACC_ONE 1'b1

`endif

//--- acc_top.v
// comparator control: registers, input routing, filter, event and interrupt
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "acc_regs.vh"

module acc_top (
	// clock and reset
	input wire i_mclk,
	input wire i_rst,
	input wire i_ce,
	// register port
	input wire [7:0] i_addr,
	input wire [7:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	output reg [7:0] o_rdata,
	// analog front end
	input wire i_raw_cmp,
	output wire o_cmp_power_on,
	output wire o_input_swap,
	output wire o_ref_on_plus,
	output wire o_ref_on_minus,
	output wire [1:0] o_reference_level_select,
	output wire [1:0] o_input_switch_select,
	output wire [7:0] o_pin_buffer_disable,
	// interrupt side
	input wire i_global_irq_enable,
	input wire i_irq_ack,
	output wire o_irq_req,
	output wire o_irq_line,
	// timer
	output wire o_timer_capture_input,
	output wire o_comparator_output_level
);

	reg [7:0] ctl1_q;
	reg [7:0] ctl2_q;
	reg [7:0] pbd_q;
	reg irq_stat_q;
	reg irq_mask_q;
	reg sync1_q;
	reg sync2_q;
	reg prev_q;
	reg [2:0] filt_cnt_q;
	reg filt_q;
	reg out_q;
	wire swap;
	wire cmp_in;
	wire cmp_level;
	wire rise;
	wire fall;
	wire edge_hit;

	function sel;
		input [7:0] a;
		input [7:0] ofs;
		begin
			sel = (a == ofs);
		end
	endfunction

	assign swap = ctl1_q[`ACC_B_SWAP];
	// ****************************************
	// analog steering
	// ****************************************
	assign o_cmp_power_on = ctl1_q[`ACC_B_ON]; // [R2]
	assign o_input_swap = swap; // [R4]
	// reference side flips with the swap
	assign o_ref_on_plus = (ctl1_q[`ACC_B_REFHI:`ACC_B_REFLO] != `ACC_REF_OFF)
		& ~(ctl1_q[`ACC_B_RSEL] ^ swap); // [R6] [R16]
	assign o_ref_on_minus = (ctl1_q[`ACC_B_REFHI:`ACC_B_REFLO] != `ACC_REF_OFF)
		& (ctl1_q[`ACC_B_RSEL] ^ swap); // [R6] [R16]
	assign o_reference_level_select =
		ctl1_q[`ACC_B_REFHI:`ACC_B_REFLO]; // [R7]
	assign o_input_switch_select =
		{ctl2_q[`ACC_B_SW1], ctl2_q[`ACC_B_SW0]}; // [R8]
	assign o_pin_buffer_disable = pbd_q; // [R9]

	// ****************************************
	// output path
	// ****************************************
	// raw level is asynchronous; only sync2 is used downstream
	assign cmp_in = sync2_q ^ swap; // [R4]
	assign cmp_level = ctl2_q[`ACC_B_FILT] ? filt_q : cmp_in; // [R5]
	assign o_comparator_output_level = out_q; // [R1] [R3]
	assign o_timer_capture_input = out_q; // [R13]
	assign rise = out_q & ~prev_q;
	assign fall = ~out_q & prev_q;
	assign edge_hit = ctl1_q[`ACC_B_POL] ? fall : rise; // [R10] [R15]

	always @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			sync1_q <= `ACC_RST_BIT;
			sync2_q <= `ACC_RST_BIT;
			prev_q <= `ACC_RST_BIT;
			out_q <= `ACC_RST_BIT;
			filt_q <= `ACC_RST_BIT;
			filt_cnt_q <= 3'h0;
		end else if (i_ce) begin
			sync1_q <= i_raw_cmp; // [R15]
			sync2_q <= sync1_q;
			// digital stand-in for the rc filter: level must hold a while
			if (cmp_in == filt_q) begin
				filt_cnt_q <= 3'h0;
			end else if (filt_cnt_q == `ACC_FILT_LEN) begin
				filt_q <= cmp_in;
				filt_cnt_q <= 3'h0;
			end else begin
				filt_cnt_q <= filt_cnt_q + 3'h1;
			end
			out_q <= ctl1_q[`ACC_B_ON] & cmp_level; // [R1] [R3]
			prev_q <= out_q;
		end
	end

	// ****************************************
	// interrupt
	// ****************************************
	// an event sets both the control one flag and irq_stat_q; requests go out on o_irq_req and o_irq_line
	assign o_irq_req = ctl1_q[`ACC_B_FLAG] & ctl1_q[`ACC_B_EN]
		& i_global_irq_enable; // [R11] [R14]
	assign o_irq_line = irq_stat_q & irq_mask_q;

	// ****************************************
	// registers
	// ****************************************
	always @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			ctl1_q <= `ACC_RST_BYTE;
			ctl2_q <= `ACC_RST_BYTE;
			pbd_q <= `ACC_RST_BYTE;
			irq_stat_q <= `ACC_RST_BIT;
			irq_mask_q <= `ACC_RST_BIT;
		end else if (i_ce) begin
			if (i_wr && sel(i_addr, `ACC_OFS_CTL1)) begin
				ctl1_q <= i_wdata; // [R12]
			end
			if (i_irq_ack) begin
				ctl1_q[`ACC_B_FLAG] <= `ACC_RST_BIT; // [R12]
			end
			// edge wins over any clear in the same cycle
			if (edge_hit) begin
				ctl1_q[`ACC_B_FLAG] <= `ACC_ONE; // [R10]
			end
			if (i_wr && sel(i_addr, `ACC_OFS_CTL2)) begin
				ctl2_q <= i_wdata & `ACC_CTL2_WMASK;
			end
			if (i_wr && sel(i_addr, `ACC_OFS_PBD)) begin
				pbd_q <= i_wdata;
			end
			if (i_wr && sel(i_addr, `ACC_OFS_MASK)) begin
				irq_mask_q <= i_wdata[0];
			end
			if (i_wr && sel(i_addr, `ACC_OFS_IRQ) && i_wdata[0]) begin
				irq_stat_q <= `ACC_RST_BIT;
			end
			if (edge_hit) begin
				irq_stat_q <= `ACC_ONE;
			end
		end
	end

	always @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_rdata <= `ACC_RST_BYTE;
		end else if (i_ce) begin
			o_rdata <= `ACC_RST_BYTE;
			if (i_rd) begin
				if (sel(i_addr, `ACC_OFS_CTL1)) begin
					o_rdata <= ctl1_q;
				end else if (sel(i_addr, `ACC_OFS_CTL2)) begin
					o_rdata <= {ctl2_q[7:1], out_q};
				end else if (sel(i_addr, `ACC_OFS_PBD)) begin
					o_rdata <= pbd_q;
				end else if (sel(i_addr, `ACC_OFS_IRQ)) begin
					o_rdata <= {7'h00, irq_stat_q};
				end else if (sel(i_addr, `ACC_OFS_MASK)) begin
					o_rdata <= {7'h00, irq_mask_q};
				end
			end
		end
	end

endmodule
`default_nettype wire

//--- acc_top_properties.sv
// port assertions for the comparator control block
`timescale 1ns/100ps
`default_nettype none
module acc_checker (
	// clock, reset, register port
	input wire i_mclk,
	input wire i_rst,
	input wire i_ce,
	input wire i_wr,
	input wire [7:0] i_addr,
	input wire [7:0] i_wdata,
	input wire i_global_irq_enable,
	// observed outputs
	input wire o_cmp_power_on,
	input wire o_ref_on_plus,
	input wire o_ref_on_minus,
	input wire [1:0] o_reference_level_select,
	input wire [1:0] o_input_switch_select,
	input wire [7:0] o_pin_buffer_disable,
	input wire o_irq_req,
	input wire o_timer_capture_input,
	input wire o_comparator_output_level
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	sequence s_wr(a);
		i_ce && i_wr && i_addr == a;
	endsequence
	chk_power_write: assert property (s_wr(8'h59) |=>
		o_cmp_power_on == $past(i_wdata[3])) else $error("power bit");
	// three cycles covers the registered gating path
	chk_off_low: assert property ((!o_cmp_power_on)[*3] |->
		!o_comparator_output_level) else $error("output not low");
	chk_timer_route: assert property (
		o_timer_capture_input == o_comparator_output_level)
		else $error("capture input differs");
	chk_irq_gate: assert property (o_irq_req |->
		i_global_irq_enable) else $error("request without enable");
	chk_ref_off: assert property (o_reference_level_select == 2'h0 |->
		!o_ref_on_plus && !o_ref_on_minus) else $error("ref not off");
	chk_ref_one: assert property (o_reference_level_select != 2'h0 |->
		o_ref_on_plus ^ o_ref_on_minus) else $error("ref steering");
	chk_pbd_write: assert property (s_wr(8'h5b) |=>
		o_pin_buffer_disable == $past(i_wdata)) else $error("pbd");
	chk_switch_write: assert property (s_wr(8'h5a) |=>
		o_input_switch_select == $past(i_wdata[4:3])) else $error("switch");
endmodule
bind acc_top acc_checker chk_i (.*);
`default_nettype wire

//--- acc_top_test.sv
// self-checking bench for the comparator control block
`timescale 1ns/100ps
`default_nettype none
module acc_top_test;
	logic i_mclk = 0, i_rst = 1, i_ce = 1, i_wr = 0, i_rd = 0;
	logic i_raw_cmp = 0, i_global_irq_enable = 1, i_irq_ack = 0;
	logic [7:0] i_addr = 8'h00, i_wdata = 8'h00;
	logic [7:0] ra [6] = '{8'h59, 8'h5a, 8'h5b, 8'h5c, 8'h5d, 8'h60};
	wire [7:0] o_rdata, o_pin_buffer_disable;
	wire [1:0] o_reference_level_select, o_input_switch_select;
	wire o_cmp_power_on, o_input_swap, o_ref_on_plus, o_ref_on_minus;
	wire o_irq_req, o_irq_line, o_timer_capture_input;
	wire o_comparator_output_level;
	int failures = 0, n_tests = 0;
	acc_top uut (.*);
	initial forever #12.5 i_mclk = ~i_mclk;
	task chk(input string s, input logic [7:0] e, g);
		n_tests++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s exp %h got %h", s, e, g);
		end
	endtask
	task w(input int n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask
	task wr(input logic [7:0] a, d);
		@(posedge i_mclk);
		i_wr <= 1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_mclk);
		i_wr <= 0;
		w(1);
	endtask
	task rd(input logic [7:0] a, e);
		@(posedge i_mclk);
		i_rd <= 1;
		i_addr <= a;
		@(posedge i_mclk);
		i_rd <= 0;
		#1 chk("rdata", e, o_rdata);
	endtask
	task wrap_up;
		$display("failures %0d tests %0d", failures, n_tests);
		if (failures == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		#200000 failures++;
		wrap_up;
	end
	initial begin
		w(4);
		i_rst <= 0;
		foreach (ra[k]) rd(ra[k], 8'h00);
		wr(8'h59, 8'h08);
		chk("pwr", 8'h01, o_cmp_power_on);
		i_raw_cmp <= 1;
		w(6);
		chk("out", 8'h01, o_comparator_output_level);
		chk("cap", 8'h01, o_timer_capture_input);
		wr(8'h59, 8'h88);
		chk("swp", 8'h01, o_input_swap);
		w(6);
		chk("swap", 8'h00, o_comparator_output_level);
		wr(8'h59, 8'h00);
		w(6);
		chk("off", 8'h00, o_comparator_output_level);
		// power-on with raw high gives a rising edge
		wr(8'h5d, 8'h01);
		wr(8'h59, 8'h0a);
		w(6);
		rd(8'h59, 8'h0b);
		chk("req", 8'h01, o_irq_req);
		chk("line", 8'h01, o_irq_line);
		i_global_irq_enable <= 0;
		w(1);
		chk("req", 8'h00, o_irq_req);
		i_global_irq_enable <= 1;
		i_irq_ack <= 1;
		w(1);
		i_irq_ack <= 0;
		rd(8'h59, 8'h0a);
		wr(8'h5c, 8'h01);
		chk("line", 8'h00, o_irq_line);
		wr(8'h5d, 8'h00);
		wr(8'h59, 8'h0e);
		i_raw_cmp <= 0;
		w(6);
		rd(8'h59, 8'h0f);
		rd(8'h5c, 8'h01);
		chk("masked", 8'h00, o_irq_line);
		wr(8'h59, 8'h0e);
		rd(8'h59, 8'h0e);
		for (int i = 0; i < 4; i++) begin
			wr(8'h59, i << 4);
			chk("lvl", i, o_reference_level_select);
			chk("ref", i ? 2 : 0, {o_ref_on_plus, o_ref_on_minus});
		end
		wr(8'h59, 8'h50);
		chk("ref", 8'h01, {o_ref_on_plus, o_ref_on_minus});
		wr(8'h59, 8'h90);
		chk("ref", 8'h01, {o_ref_on_plus, o_ref_on_minus});
		wr(8'h5a, 8'h04);
		wr(8'h59, 8'h08);
		i_raw_cmp <= 1;
		w(2);
		i_raw_cmp <= 0;
		w(8);
		chk("glitch", 8'h00, o_comparator_output_level);
		i_raw_cmp <= 1;
		w(10);
		chk("filt", 8'h01, o_comparator_output_level);
		wr(8'h5a, 8'h18);
		chk("sw", 8'h03, o_input_switch_select);
		rd(8'h5a, 8'h19);
		wr(8'h5b, 8'ha5);
		chk("pbd", 8'ha5, o_pin_buffer_disable);
		rd(8'h5b, 8'ha5);
		// enable low freezes every register, bus writes included
		i_ce <= 0;
		wr(8'h5b, 8'h00);
		chk("ce", 8'ha5, o_pin_buffer_disable);
		i_ce <= 1;
		w(1);
		wr(8'h59, 8'h00);
		chk("pwr", 8'h00, o_cmp_power_on);
		chk("swp", 8'h00, o_input_swap);
		wrap_up;
	end
endmodule
`default_nettype wire
